// ==== hw/rtpd_pkg.sv ====
// Package: register map, field positions and reset values of the clock-control block
package rtpd_pkg;

  // ----------------------------------------------------------------
  // Register word addresses (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] RTPD_IDX_REF_CTRL   = 4'h0;
  localparam logic [3:0] RTPD_IDX_TRIM       = 4'h1;
  localparam logic [3:0] RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR      = 4'h2;
  localparam logic [3:0] RTPD_IDX_STATUS     = 4'h3;
  localparam logic [3:0] RTPD_IDX_UNLOCK     = 4'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTPD_TRIM_LSB      = 23;
  localparam int RTPD_TRIM_W        = 9;
  localparam int RTPD_REFDIV_LSB    = 16;
  localparam int RTPD_REFDIV_W      = 15;
  localparam int RTPD_REF_ON_BIT    = 15;
  localparam int RTPD_DIVSW_BIT     = 9;
  localparam int RTPD_ACTIVE_BIT    = 8;
  localparam int RTPD_PB_ON_BIT     = 15;
  localparam int RTPD_PB_RDY_BIT    = 11;
  localparam int RTPD_PB_DIV_W      = 7;
  localparam int RTPD_ST_UPLL_BIT   = 8;
  localparam int RTPD_ST_SPLL_BIT   = 7;
  localparam int RTPD_ST_LPRC_BIT   = 5;
  localparam int RTPD_ST_SOSC_BIT   = 4;
  localparam int RTPD_ST_POSC_BIT   = 2;
  localparam int RTPD_ST_DSPLL_BIT  = 1;
  localparam int RTPD_ST_FRC_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values and unlock keys
  // ----------------------------------------------------------------
  localparam logic [RTPD_TRIM_W-1:0]   RTPD_TRIM_RST    = 9'h000;
  localparam logic [RTPD_REFDIV_W-1:0] RTPD_REFDIV_RST  = 15'h0000;
  localparam logic                     RTPD_PB_ON_RST   = 1'b1;
  localparam logic [3:0]               RTPD_PB_HI_RST   = 4'h0;
  localparam logic [31:0]              RTPD_UNLOCK_KEY1 = 32'hAA99_6655;
  localparam logic [31:0]              RTPD_UNLOCK_KEY2 = 32'h5566_99AA;
  // Reference switch completes one system clock after the count reaches this value
  localparam logic [3:0]               RTPD_SWITCH_CYC  = 4'h4;

endpackage : rtpd_pkg

// ==== hw/rtpd_pb_divider.sv ====
// Peripheral bus clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module rtpd_pb_divider (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_enable,
  input  wire logic [6:0] i_divisor,
  input  wire logic       i_load,
  // Status and output
  output logic            o_busy,
  output logic            o_tick
);

  logic [6:0] count_r;
  logic [6:0] div_r;
  logic       busy_r;
  logic       tick_r;
  wire        wrap = (count_r >= div_r);

  // ----------------------------------------------------------------
  // Divider; a new divisor acts at once, busy until the count first meets it
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_r <= 7'h00;
      div_r   <= 7'h00;
      busy_r  <= 1'b0;
      tick_r  <= 1'b0;
    end else begin
      tick_r <= i_enable & wrap;
      if (i_load) begin
        div_r  <= i_divisor;
        busy_r <= 1'b1;
      end else if (wrap) begin
        busy_r <= 1'b0;
      end
      count_r <= wrap ? 7'h00 : count_r + 7'h01;
    end
  end

  assign o_busy = busy_r;
  assign o_tick = tick_r;

endmodule : rtpd_pb_divider

// ==== hw/rtpd_clock_ctrl.sv ====
// Reference trim, peripheral bus divisor and oscillator status registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rtpd_clock_ctrl
  import rtpd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Fuse default and oscillator ready pins
  input  wire logic [2:0]  i_fuse_bus_divisor_default,
  input  wire logic        i_ref_clock_active,
  input  wire logic        i_usb_pll_ready,
  input  wire logic        i_sys_pll_ready,
  input  wire logic        i_lowpower_rc_ready,
  input  wire logic        i_secondary_osc_ready,
  input  wire logic        i_primary_osc_ready,
  input  wire logic        i_divided_sys_pll_ready,
  input  wire logic        i_fast_rc_ready,
  // Clock outputs
  output logic             o_peripheral_bus_clock_en,
  output logic [23:0]      o_ref_divisor_effective,
  output logic             o_ref_enable
);

  // ----------------------------------------------------------------
  // Input synchronisers (two flops per asynchronous pin)
  // ----------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pin_async;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign pin_async = {i_fuse_bus_divisor_default, i_ref_clock_active, i_usb_pll_ready,
                      i_sys_pll_ready, i_lowpower_rc_ready, i_secondary_osc_ready,
                      i_primary_osc_ready, i_divided_sys_pll_ready, i_fast_rc_ready};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      // No reset here: the fuse value must already be settled when reset releases
      always_ff @(posedge i_clk) begin
        sync1_r[g] <= pin_async[g];
        sync2_r[g] <= sync1_r[g];
      end
    end
  endgenerate

  wire [2:0] fuse_div_s = sync2_r[10:8];
  wire       active_s   = sync2_r[7];
  wire       upll_s     = sync2_r[6];
  wire       spll_s     = sync2_r[5];
  wire       lprc_s     = sync2_r[4];
  wire       sosc_s     = sync2_r[3];
  wire       posc_s     = sync2_r[2];
  wire       dspll_s    = sync2_r[1];
  wire       frc_s      = sync2_r[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [RTPD_REFDIV_W-1:0] ref_divider_value_r;
  logic                     ref_on_r;
  logic                     divider_switch_request_r;
  logic [3:0]               switch_cnt_r;
  logic [RTPD_TRIM_W-1:0]   ref_trim_fraction_r;    // Staged value as written
  logic [RTPD_TRIM_W-1:0]   trim_applied_r;         // Value driving the divider
  logic                     pb_on_r;
  logic [RTPD_PB_DIV_W-1:0] periph_bus_divisor_field_r;
  logic                     unlocked_r;
  logic                     key1_seen_r;
  logic                     fuse_load_r;
  logic                     ack_r;
  logic [31:0]              rdata_r;
  logic [23:0]              ref_eff_r;

  // ----------------------------------------------------------------
  // Bus decode: one wait state, accepted on the cycle ack_r is high
  // ----------------------------------------------------------------
  wire        sel_ref    = (i_avs_address == RTPD_IDX_REF_CTRL);
  wire        sel_trim   = (i_avs_address == RTPD_IDX_TRIM);
  wire        sel_periph_bus_clock_divisor  = (i_avs_address == RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR);
  wire        sel_status = (i_avs_address == RTPD_IDX_STATUS);
  wire        sel_unlock = (i_avs_address == RTPD_IDX_UNLOCK);
  wire        req        = (i_avs_read | i_avs_write) & ~ack_r;
  wire        wr_go      = i_avs_write & req;
  // Partial writes are dropped whole, so a field is never half updated
  wire        full_word  = (i_avs_byteenable == 4'hF);
  wire        wr_ref     = wr_go & full_word & sel_ref;
  wire        wr_trim    = wr_go & full_word & sel_trim;
  wire        wr_periph_bus_clock_divisor   = wr_go & full_word & sel_periph_bus_clock_divisor;
  wire        wr_unlock  = wr_go & full_word & sel_unlock;
  wire        key1_match = (i_avs_writedata == RTPD_UNLOCK_KEY1);
  wire        key2_match = (i_avs_writedata == RTPD_UNLOCK_KEY2);
  wire [RTPD_TRIM_W-1:0]   trim_wdata   = i_avs_writedata[RTPD_TRIM_LSB +: RTPD_TRIM_W];
  wire [RTPD_PB_DIV_W-1:0] pb_wdata     = i_avs_writedata[RTPD_PB_DIV_W-1:0];
  wire [RTPD_PB_DIV_W-1:0] fuse_divisor = {RTPD_PB_HI_RST, fuse_div_s};
  wire        pb_busy;
  wire        pb_ready   = ~pb_busy & ~fuse_load_r;
  wire        pb_div_ok  = wr_periph_bus_clock_divisor & unlocked_r & pb_ready;
  wire        pb_on_ok   = wr_periph_bus_clock_divisor & unlocked_r;
  wire        sw_req_wr  = wr_ref & i_avs_writedata[RTPD_DIVSW_BIT];
  wire        sw_done    = divider_switch_request_r & (switch_cnt_r == RTPD_SWITCH_CYC);

  logic [31:0] rd_ref;
  logic [31:0] rd_trim;
  logic [31:0] rd_periph_bus_clock_divisor;
  logic [31:0] rd_status;

  // Each word starts from zero so reserved bits can only ever read zero
  always_comb begin
    rd_ref                                   = 32'h0000_0000;
    rd_ref[RTPD_REFDIV_LSB +: RTPD_REFDIV_W] = ref_divider_value_r;
    rd_ref[RTPD_REF_ON_BIT]                  = ref_on_r;
    rd_ref[RTPD_DIVSW_BIT]                   = divider_switch_request_r;
    rd_ref[RTPD_ACTIVE_BIT]                  = active_s;
    rd_trim                                  = 32'h0000_0000;
    rd_trim[RTPD_TRIM_LSB +: RTPD_TRIM_W]    = ref_trim_fraction_r;
    rd_periph_bus_clock_divisor                                 = 32'h0000_0000;
    rd_periph_bus_clock_divisor[RTPD_PB_ON_BIT]                 = pb_on_r;
    rd_periph_bus_clock_divisor[RTPD_PB_RDY_BIT]                = pb_ready;
    rd_periph_bus_clock_divisor[RTPD_PB_DIV_W-1:0]              = periph_bus_divisor_field_r;
    rd_status                                = 32'h0000_0000;
    rd_status[RTPD_ST_UPLL_BIT]              = upll_s;
    rd_status[RTPD_ST_SPLL_BIT]              = spll_s;
    rd_status[RTPD_ST_LPRC_BIT]              = lprc_s;
    rd_status[RTPD_ST_SOSC_BIT]              = sosc_s;
    rd_status[RTPD_ST_POSC_BIT]              = posc_s;
    rd_status[RTPD_ST_DSPLL_BIT]             = dspll_s;
    rd_status[RTPD_ST_FRC_BIT]               = frc_s;
  end

  wire [31:0] rd_mux     = sel_ref    ? rd_ref    :
                           sel_trim   ? rd_trim   :
                           sel_periph_bus_clock_divisor  ? rd_periph_bus_clock_divisor  :
                           sel_status ? rd_status :
                           32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req;
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence: two keys back to back, one divisor write allowed
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key1_seen_r <= 1'b0;
      unlocked_r  <= 1'b0;
    end else if (wr_unlock) begin
      key1_seen_r <= key1_match;
      unlocked_r  <= key1_seen_r & key2_match;
    end else if (wr_go) begin
      key1_seen_r <= 1'b0;
      unlocked_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reference control: enable, divider and switch request
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_on_r                 <= 1'b0;
      ref_divider_value_r      <= RTPD_REFDIV_RST;
      divider_switch_request_r <= 1'b0;
      switch_cnt_r             <= 4'h0;
    end else begin
      if (wr_ref) begin
        ref_on_r            <= i_avs_writedata[RTPD_REF_ON_BIT];
        ref_divider_value_r <= i_avs_writedata[RTPD_REFDIV_LSB +: RTPD_REFDIV_W];
      end
      // A new request wins over completion in the same cycle
      if (sw_req_wr) begin
        divider_switch_request_r <= 1'b1;
        switch_cnt_r             <= 4'h0;
      end else if (sw_done) begin
        divider_switch_request_r <= 1'b0;
      end else if (divider_switch_request_r) begin
        switch_cnt_r <= switch_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim: staged on write, applied directly when off or at switch end
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_trim_fraction_r <= RTPD_TRIM_RST;
      trim_applied_r      <= RTPD_TRIM_RST;
    end else begin
      if (wr_trim) begin
        ref_trim_fraction_r <= trim_wdata;
      end
      if (wr_trim & ~ref_on_r) begin
        trim_applied_r <= trim_wdata;
      end else if (sw_done) begin
        trim_applied_r <= ref_trim_fraction_r;
      end
    end
  end

  // Effective divisor in 1/512 units; a zero divider passes the source through
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_eff_r <= 24'h00_0000;
    end else if (ref_divider_value_r == RTPD_REFDIV_RST) begin
      ref_eff_r <= 24'h00_0000;
    end else begin
      ref_eff_r <= {ref_divider_value_r, trim_applied_r};
    end
  end

  // ----------------------------------------------------------------
  // Peripheral bus divisor; fuse value caught one cycle after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pb_on_r                    <= RTPD_PB_ON_RST;
      periph_bus_divisor_field_r <= 7'h00;
      fuse_load_r                <= 1'b1;
    end else begin
      if (fuse_load_r) begin
        fuse_load_r                <= 1'b0;
        periph_bus_divisor_field_r <= fuse_divisor;
      end else if (pb_div_ok) begin
        periph_bus_divisor_field_r <= pb_wdata;
      end
      if (pb_on_ok) begin
        pb_on_r <= i_avs_writedata[RTPD_PB_ON_BIT];
      end
    end
  end

  wire pb_load = pb_div_ok | fuse_load_r;
  wire pb_tick;
  wire [RTPD_PB_DIV_W-1:0] pb_next_div = fuse_load_r ? fuse_divisor : pb_wdata;
  rtpd_pb_divider u_pb_divider (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_enable  (pb_on_r),
    .i_divisor (pb_next_div),
    .i_load    (pb_load),
    .o_busy    (pb_busy),
    .o_tick    (pb_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic pb_en_r;
  logic ref_en_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pb_en_r  <= 1'b0;
      ref_en_r <= 1'b0;
    end else begin
      pb_en_r  <= pb_tick;
      ref_en_r <= ref_on_r;
    end
  end

  assign o_avs_readdata            = rdata_r;
  assign o_avs_waitrequest         = ~ack_r;
  assign o_peripheral_bus_clock_en = pb_en_r;
  assign o_ref_divisor_effective   = ref_eff_r;
  assign o_ref_enable              = ref_en_r;

endmodule : rtpd_clock_ctrl

// ==== bench/rtpd_props.sv ====
// Checker for the bus handshake and output relations of the clock-control block
`timescale 1ns/1ps
module rtpd_props
  import rtpd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_peripheral_bus_clock_en,
  input wire logic [23:0] o_ref_divisor_effective,
  input wire logic        o_ref_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire        req    = i_avs_read | i_avs_write;
  wire        rd_ack = i_avs_read & ~o_avs_waitrequest;
  wire        wr_ack = i_avs_write & ~o_avs_waitrequest & (i_avs_byteenable == 4'hF);
  wire [3:0]  a      = i_avs_address;
  wire [31:0] d      = o_avs_readdata;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_wait_one_cycle: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_no_ack: assert property (!req |=> o_avs_waitrequest)
    else $error("answer given without a request");
  a_trim_low_zero: assert property (rd_ack && a == RTPD_IDX_TRIM |-> d[22:0] == 23'h00_0000)
    else $error("trim register low bits not zero");
  a_status_gaps: assert property (rd_ack && a == RTPD_IDX_STATUS |-> d[31:9] == 23'h00_0000 && !d[6] && !d[3])
    else $error("status register unused bits not zero");
  a_pb_gaps: assert property (rd_ack && a == RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR |-> d[31:16] == 16'h0000 && d[14:12] == 3'h0 && d[10:7] == 4'h0)
    else $error("bus divisor unused bits not zero");
  a_pb_gated: assert property (rd_ack && a == RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR && !d[15] |-> !o_peripheral_bus_clock_en [*2])
    else $error("bus clock pulse while output is off");
  a_ref_zero_trim: assert property (o_ref_divisor_effective[23:9] == 15'h0000 |-> o_ref_divisor_effective[8:0] == 9'h000)
    else $error("trim applied with zero reference divider");
  a_ref_en_follow: assert property (wr_ack && a == RTPD_IDX_REF_CTRL |-> ##2 o_ref_enable == $past(i_avs_writedata[15], 2))
    else $error("reference enable does not follow control write");
  c_pb_off: cover property (rd_ack && a == RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR && !d[15]);
  c_tick_run: cover property (o_peripheral_bus_clock_en ##1 o_peripheral_bus_clock_en);
  c_unlock: cover property (wr_ack && a == RTPD_IDX_UNLOCK);
endmodule : rtpd_props

bind rtpd_clock_ctrl rtpd_props rtpd_props_inst (.i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_peripheral_bus_clock_en,
  .o_ref_divisor_effective, .o_ref_enable);

// ==== bench/tb_top.sv ====
// Testbench for the clock-control block: registers, bus clock division, reference trim
`timescale 1ns/1ps
module tb_top;
  import rtpd_pkg::*;
  typedef struct packed {logic wr; logic [3:0] adr; logic [31:0] dat; logic [31:0] exp;} rtpd_row_t;
  logic        i_clk   = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  adr     = 4'h0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [2:0]  fuse    = 3'h6;
  logic        act     = 1'b0;
  logic [6:0]  pins    = 7'h55;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        wreq;
  logic        tick;
  logic [23:0] eff;
  logic        ref_en;
  logic [6:0]  divs [4] = '{7'h00, 7'h01, 7'h06, 7'h7F};
  rtpd_row_t   rows [9];
  int          miscompares = 0;
  int          n_compared  = 0;
  int          n;
  always #5 i_clk = ~i_clk;
  rtpd_clock_ctrl rtpd_clock_ctrl_inst (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_fuse_bus_divisor_default(fuse), .i_ref_clock_active(act),
    .i_usb_pll_ready(pins[6]), .i_sys_pll_ready(pins[5]), .i_lowpower_rc_ready(pins[4]),
    .i_secondary_osc_ready(pins[3]), .i_primary_osc_ready(pins[2]), .i_divided_sys_pll_ready(pins[1]),
    .i_fast_rc_ready(pins[0]), .o_peripheral_bus_clock_en(tick), .o_ref_divisor_effective(eff),
    .o_ref_enable(ref_en));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low; the answer is taken at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge i_clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (wreq !== 1'b0) miscompares++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      bus(1'b0, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_0000);
      k++;
    end while (q[RTPD_PB_RDY_BIT] !== 1'b1 && k < 200);
    if (q[RTPD_PB_RDY_BIT] !== 1'b1) miscompares++;
  endtask : wait_rdy
  task automatic set_div(input logic on, input logic [6:0] dv);
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY1);
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY2);
    bus(1'b1, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, {16'h0000, on, 8'h00, dv});
    wait_rdy();
  endtask : set_div
  // Cycles from one bus clock pulse to the next
  task automatic gap(output int g);
    int k;
    k = 0;
    g = 0;
    do begin @(posedge i_clk); k++; end while (tick !== 1'b1 && k < 300);
    if (tick !== 1'b1) miscompares++;
    do begin @(posedge i_clk); g++; end while (tick !== 1'b1 && g < 300);
  endtask : gap
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    rows = '{'{1'b0, RTPD_IDX_STATUS, 32'h0000_0000, 32'h0000_0125}, '{1'b1, RTPD_IDX_TRIM, 32'hFFFF_FFFF, 32'h0},
             '{1'b0, RTPD_IDX_TRIM, 32'h0000_0000, 32'hFF80_0000}, '{1'b0, 4'h5, 32'h0000_0000, 32'h0000_0000},
             '{1'b1, 4'h7, 32'hDEAD_BEEF, 32'h0}, '{1'b0, 4'h7, 32'h0000_0000, 32'h0000_0000},
             '{1'b1, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_0005, 32'h0}, '{1'b0, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_0000, 32'h0000_8806},
             '{1'b1, RTPD_IDX_REF_CTRL, 32'h0003_0000, 32'h0}};
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].adr, rows[i].dat);
      if (!rows[i].wr) chk(q, rows[i].exp);
    end
    repeat (3) @(posedge i_clk);
    chk({8'h00, eff}, 32'h0000_07FF);
    pins <= 7'h2A;
    repeat (4) @(posedge i_clk);
    bus(1'b0, RTPD_IDX_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0092);
    foreach (divs[i]) begin
      set_div(1'b1, divs[i]);
      gap(n);
      chk(32'(n), 32'(divs[i]) + 32'h1);
    end
    set_div(1'b0, 7'h7F);
    n = 0;
    repeat (300) begin @(posedge i_clk); if (tick === 1'b1) n++; end
    chk(32'(n), 32'h0000_0000);
    set_div(1'b1, 7'h7F);
    gap(n);
    chk(32'(n), 32'h0000_0080);
    // A divisor above the running count right after a pulse keeps ready low until the count meets it
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY1);
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY2);
    bus(1'b1, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_8070);
    bus(1'b0, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_0000);
    chk(q, 32'h0000_8070);
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY1);
    bus(1'b1, RTPD_IDX_UNLOCK, RTPD_UNLOCK_KEY2);
    bus(1'b1, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_8009);
    wait_rdy();
    chk(q, 32'h0000_8870);
    act <= 1'b1;
    bus(1'b1, RTPD_IDX_REF_CTRL, 32'h0003_8000);
    repeat (4) @(posedge i_clk);
    bus(1'b1, RTPD_IDX_TRIM, 32'h0080_0000);
    repeat (8) @(posedge i_clk);
    chk({8'h00, eff}, 32'h0000_07FF);
    bus(1'b1, RTPD_IDX_REF_CTRL, 32'h0003_8200);
    bus(1'b0, RTPD_IDX_REF_CTRL, 32'h0000_0000);
    chk(q, 32'h0003_8300);
    repeat (8) @(posedge i_clk);
    chk({8'h00, eff}, 32'h0000_0601);
    bus(1'b0, RTPD_IDX_REF_CTRL, 32'h0000_0000);
    chk(q, 32'h0003_8100);
    act <= 1'b0;
    bus(1'b1, RTPD_IDX_REF_CTRL, 32'h0000_0000);
    repeat (4) @(posedge i_clk);
    chk({8'h00, eff}, 32'h0000_0000);
    fuse <= 3'h3;
    i_reset <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (10) @(posedge i_clk);
    bus(1'b0, RTPD_IDX_PERIPH_BUS_CLOCK_DIVISOR, 32'h0000_0000);
    chk(q, 32'h0000_8803);
    bus(1'b0, RTPD_IDX_TRIM, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    complete_run();
  end
endmodule : tb_top
